// ### hdl/rbac_pkg.sv
// constants and state type for the register bit access cell bank
package rbac_pkg;

  // ==========================================================
  // data word layout
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned F_RO     = 0;   // read only, tracks hardware
  localparam int unsigned F_SOR    = 1;   // set on read
  localparam int unsigned F_COR    = 2;   // clear on read
  localparam int unsigned F_WO     = 3;   // write only
  localparam int unsigned F_W1C    = 4;   // write one to clear
  localparam int unsigned F_WAC    = 5;   // write anything to clear
  localparam int unsigned F_LL     = 6;   // latch low status
  localparam int unsigned F_LH     = 7;   // latch high status
  localparam int unsigned F_SC     = 8;   // self clearing
  localparam int unsigned F_SS     = 9;   // self setting
  localparam int unsigned F_STICKY = 10;  // sticky high status
  localparam int unsigned F_KOLR   = 11;  // kept on lite reset
  localparam int unsigned F_KOSR   = 12;  // kept on soft reset
  localparam int unsigned F_RW     = 13;  // plain read/write
  localparam int unsigned F_RES_LO = 14;  // reserved field low bit
  localparam int unsigned F_RES_HI = 15;  // reserved field high bit

  // ==========================================================
  // complete state of the bank
  typedef struct packed {
    logic              ro;          // read only copy
    logic              sor;         // set on read
    logic              cor;         // clear on read
    logic              wo;          // write only
    logic              w1c;         // write one to clear
    logic              write_any_clear;         // write anything to clear
    logic              ll_latched;  // low level caught
    logic              ll;          // latch low value
    logic              lh_latched;  // high level caught
    logic              lh;          // latch high value
    logic              sc;          // self clearing
    logic              ss;          // self setting
    logic              sticky;      // sticky high status
    logic              sticky_read; // read since it went high
    logic              kolr;        // immune to lite reset
    logic              kosr;        // immune to soft reset
    logic              rw;          // plain read/write
    logic [DATA_W-1:0] rdata;       // read data
  } rbac_state_t;

  // ==========================================================
  // reset values: self setting bit rests at one
  localparam rbac_state_t RESET_STATE = '{
    ss: 1'b1, ll: 1'b1, rdata: 16'h0000, default: 1'b0};

endpackage : rbac_pkg

// ### hdl/rbac_bank.sv
// register bit access cell bank, one cell of each access kind
`timescale 1ns/10ps
`default_nettype none

// Operation
// RL1: read only bit ignores writes
// RL2: read sets the set on read bit
// RL3: read returns value then clears it
// RL4: write only bit reads as don't care
// RL5: writing one clears, zero leaves alone
// RL6: any write clears the bit
// RL7: latch holds event until register read
// RL8: self clearing bit drops when action done
// RL9: self setting bit returns to one
// RL10: sticky high falls after read, condition gone
// RL11: lite reset spares the tagged bit
// RL12: soft reset spares the tagged bit
// RL13: reserved written zero, read undefined
// RL14: hardware set beats software clear
// RL15: hard reset restores every bit
module rbac_bank (
  // clock and resets
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        lite_rst,
  input  wire logic        soft_rst,
  // software access strobes
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  // hardware side
  input  wire logic        hw_status,
  input  wire logic        sor_clear,
  input  wire logic        cor_event,
  input  wire logic        w1c_event,
  input  wire logic        wac_event,
  input  wire logic        ll_source,
  input  wire logic        lh_source,
  input  wire logic        sc_done,
  input  wire logic        ss_done,
  input  wire logic        sticky_cond,
  // control outputs
  output logic             wo_value,
  output logic             sc_go,
  output logic             ss_value,
  output logic             kolr_value,
  output logic             kosr_value,
  output logic             rw_value
);

  // ========================================================
  // state
  rbac_pkg::rbac_state_t s;       // registered state
  rbac_pkg::rbac_state_t next_s;  // next state

  // ========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.ro = hw_status;  // hardware only owner, see RL1
    // set on read, hardware may clear it
    if (sor_clear) begin
      next_s.sor = 1'b0;
    end
    if (rd) begin
      next_s.sor = 1'b1;  // see RL2
    end
    // clear on read, event wins, see RL3 see RL14
    next_s.cor = cor_event | (s.cor & ~rd);
    // write only storage, see RL4
    if (wr) begin
      next_s.wo = wdata[rbac_pkg::F_WO];
    end
    // write one clear, event wins, see RL5 see RL14
    next_s.w1c = w1c_event | (s.w1c & ~(wr & wdata[rbac_pkg::F_W1C]));
    // write any clear, see RL6 see RL14
    next_s.write_any_clear = wac_event | (s.write_any_clear & ~wr);
    // latch low: hold zero until read, then track, see RL7
    next_s.ll_latched = ~ll_source | (s.ll_latched & ~rd);
    next_s.ll         = ~next_s.ll_latched & ll_source;
    // latch high: hold one until read, then track, see RL7
    next_s.lh_latched = lh_source | (s.lh_latched & ~rd);
    next_s.lh         = next_s.lh_latched | lh_source;
    // self clearing: set by write of one only, see RL8
    if (sc_done) begin
      next_s.sc = 1'b0;
    end
    if (wr && wdata[rbac_pkg::F_SC]) begin
      next_s.sc = 1'b1;
    end
    // self setting: cleared by write of zero only, see RL9
    if (wr && !wdata[rbac_pkg::F_SS]) begin
      next_s.ss = 1'b0;
    end
    if (ss_done) begin
      next_s.ss = 1'b1;
    end
    // sticky high: falls only once read and condition gone, see RL10
    next_s.sticky      = sticky_cond | (s.sticky & ~(s.sticky_read | rd));
    next_s.sticky_read = next_s.sticky & (s.sticky_read | (rd & s.sticky));
    // plain and immune bits
    if (wr) begin
      next_s.kolr = wdata[rbac_pkg::F_KOLR];
      next_s.kosr = wdata[rbac_pkg::F_KOSR];
      next_s.rw   = wdata[rbac_pkg::F_RW];
    end
    // read data captured before side effects
    if (rd) begin
      next_s.rdata = '0;  // reserved and write only read zero, see RL13
      next_s.rdata[rbac_pkg::F_RO]     = s.ro;
      next_s.rdata[rbac_pkg::F_SOR]    = s.sor;
      next_s.rdata[rbac_pkg::F_COR]    = s.cor;
      next_s.rdata[rbac_pkg::F_W1C]    = s.w1c;
      next_s.rdata[rbac_pkg::F_WAC]    = s.write_any_clear;
      next_s.rdata[rbac_pkg::F_LL]     = s.ll;
      next_s.rdata[rbac_pkg::F_LH]     = s.lh;
      next_s.rdata[rbac_pkg::F_SC]     = s.sc;
      next_s.rdata[rbac_pkg::F_SS]     = s.ss;
      next_s.rdata[rbac_pkg::F_STICKY] = s.sticky;
      next_s.rdata[rbac_pkg::F_KOLR]   = s.kolr;
      next_s.rdata[rbac_pkg::F_KOSR]   = s.kosr;
      next_s.rdata[rbac_pkg::F_RW]     = s.rw;
    end
    // lite reset keeps only its tagged bit, see RL11 see RL15
    if (lite_rst) begin
      next_s      = rbac_pkg::RESET_STATE;
      next_s.kolr = s.kolr;
    end
    // soft reset keeps only its tagged bit, see RL12 see RL15
    else if (soft_rst) begin
      next_s      = rbac_pkg::RESET_STATE;
      next_s.kosr = s.kosr;
    end
  end

  // ========================================================
  // state register, hard reset loads RESET_STATE (ss and ll at one), see RL15
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= rbac_pkg::RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================
  // outputs straight from flops
  assign rdata      = s.rdata;
  assign wo_value   = s.wo;
  assign sc_go      = s.sc;
  assign ss_value   = s.ss;
  assign kolr_value = s.kolr;
  assign kosr_value = s.kosr;
  assign rw_value   = s.rw;

  // ========================================================
  // assertions
  logic quiet;  // no lite or soft reset this cycle
  assign quiet = !lite_rst && !soft_rst;

  property p_ro_read;  // see RL1
    @(posedge clock) disable iff (rst)
      (rd && quiet && $past(quiet) && !$past(rst))  // copy not wiped last cycle
        |=> rdata[rbac_pkg::F_RO] == $past(hw_status, 2);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("read only bit wrong");  // see RL1

  property p_sor;
    @(posedge clock) disable iff (rst) (rd && quiet) |=> s.sor;
  endproperty
  a_sor: assert property (p_sor) else $error("set on read did not set");  // see RL2

  property p_cor;
    @(posedge clock) disable iff (rst)
      (rd && s.cor && !cor_event && quiet) |=> !s.cor && rdata[rbac_pkg::F_COR];
  endproperty
  a_cor: assert property (p_cor) else $error("clear on read failed");  // see RL3

  property p_wo;
    @(posedge clock) disable iff (rst) (rd && quiet) |=> !rdata[rbac_pkg::F_WO];
  endproperty
  a_wo: assert property (p_wo) else $error("write only read not zero");  // see RL4

  property p_w1c_zero;
    @(posedge clock) disable iff (rst)
      (wr && !wdata[rbac_pkg::F_W1C] && !w1c_event && quiet) |=> s.w1c == $past(s.w1c);
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("zero write changed bit");  // see RL5

  property p_wac;
    @(posedge clock) disable iff (rst) (wr && !wac_event) |=> !s.write_any_clear;
  endproperty
  a_wac: assert property (p_wac) else $error("write any did not clear");  // see RL6

  property p_lh_hold;
    @(posedge clock) disable iff (rst)
      (s.lh_latched && !rd && quiet) |=> s.lh [*1];
  endproperty
  a_lh_hold: assert property (p_lh_hold) else $error("latch high lost");  // see RL7

  property p_sc;
    @(posedge clock) disable iff (rst)
      (sc_done && !(wr && wdata[rbac_pkg::F_SC])) |=> !sc_go;
  endproperty
  a_sc: assert property (p_sc) else $error("self clear did not clear");  // see RL8

  property p_ss;
    @(posedge clock) disable iff (rst) (ss_done) |=> ss_value;
  endproperty
  a_ss: assert property (p_ss) else $error("self set did not set");  // see RL9

  property p_sticky;
    @(posedge clock) disable iff (rst)
      (s.sticky && !s.sticky_read && !rd && quiet) |=> s.sticky;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky fell before read");  // see RL10

  property p_kolr;
    @(posedge clock) disable iff (rst) (lite_rst && !wr) |=> kolr_value == $past(kolr_value);
  endproperty
  a_kolr: assert property (p_kolr) else $error("lite reset hit kept bit");  // see RL11

  property p_kosr;
    @(posedge clock) disable iff (rst)
      (soft_rst && !lite_rst) |=> kosr_value == $past(kosr_value);
  endproperty
  a_kosr: assert property (p_kosr) else $error("soft reset hit kept bit");  // see RL12

  property p_res;
    @(posedge clock) disable iff (rst) rdata[rbac_pkg::F_RES_HI:rbac_pkg::F_RES_LO] == 2'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits not zero");  // see RL13

  property p_set_wins;
    @(posedge clock) disable iff (rst) (w1c_event && quiet) |=> s.w1c;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");  // see RL14

  property p_hard;
    @(posedge clock) rst |=> (s == rbac_pkg::RESET_STATE);
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset incomplete");  // see RL15

  // main scenarios
  c_cor_read: cover property (@(posedge clock) disable iff (rst) s.cor ##1 rd ##1 !s.cor);
  c_sticky_fall: cover property (@(posedge clock) disable iff (rst)
    s.sticky && rd && !sticky_cond ##1 !s.sticky);
  c_sc_cycle: cover property (@(posedge clock) disable iff (rst) sc_go ##[1:20] !sc_go);
  c_lite_keep: cover property (@(posedge clock) disable iff (rst) kolr_value && lite_rst);

endmodule : rbac_bank

`default_nettype wire

// ### test/rbac_bank_tb_top.sv
// self-checking bench for the register bit access cell bank
`timescale 1ns/10ps
`default_nettype none

module rbac_bank_tb_top;
  // ==========
  // expected read note
  typedef struct packed {
    logic [15:0] e;  // expected bits
    logic [15:0] m;  // bits that matter
  } rbac_note_t;

  // ==========
  // signals
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        lite_rst = 1'b0;
  logic        soft_rst = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        hw_status = 1'b0;
  logic        sor_clear = 1'b0;
  logic        cor_event = 1'b0;
  logic        w1c_event = 1'b0;
  logic        wac_event = 1'b0;
  logic        ll_source = 1'b1;
  logic        lh_source = 1'b0;
  logic        sc_done = 1'b0;
  logic        ss_done = 1'b0;
  logic        sticky_cond = 1'b0;
  logic        wo_value, sc_go, ss_value, kolr_value, kosr_value, rw_value;
  rbac_note_t  notes[$];       // pending read notes
  rbac_note_t  n;              // note under compare
  int          failures = 0;
  int          total_checks = 0;
  int          seed = 32'hf54f;
  logic [15:0] d;              // random write word

  rbac_bank i_dut (.clock, .rst, .lite_rst, .soft_rst, .rd, .wr, .wdata, .rdata,
    .hw_status, .sor_clear, .cor_event, .w1c_event, .wac_event, .ll_source, .lh_source,
    .sc_done, .ss_done, .sticky_cond, .wo_value, .sc_go, .ss_value, .kolr_value,
    .kosr_value, .rw_value);

  // 100 MHz clock
  always #5 clock = ~clock;

  // ==========
  // helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic bit_chk(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask : bit_chk

  // control outputs packed: rw kosr kolr ss sc wo
  function automatic logic [15:0] outs();
    return {10'h000, rw_value, kosr_value, kolr_value, ss_value, sc_go, wo_value};
  endfunction : outs

  task automatic cyc(input int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc

  // read with a note of what must come back
  task automatic rd_op(input logic [15:0] e, input logic [15:0] m);
    rd = 1'b1;
    notes.push_back('{e, m});
    cyc();
    rd = 1'b0;
    cyc();
  endtask : rd_op

  task automatic wr_op(input logic [15:0] v);
    wr = 1'b1;
    wdata = v;
    cyc();
    wr = 1'b0;
    cyc();
  endtask : wr_op

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc();
    s = 1'b0;
    cyc();
  endtask : pulse

  // hardware event and write in the same cycle
  task automatic clash(ref logic s, input logic [15:0] v);
    s = 1'b1;
    wr = 1'b1;
    wdata = v;
    cyc();
    s = 1'b0;
    wr = 1'b0;
    cyc();
  endtask : clash

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // ==========
  // monitor: oldest note against read data
  always @(posedge clock) begin
    if (rd === 1'b1) begin
      #2;
      if (notes.size() == 0) begin
        chk("note queue", 16'h0001, 16'h0000);
      end else begin
        n = notes.pop_front();
        chk("rdata", n.e & n.m, rdata & n.m);
      end
    end
  end

  // hang guard
  initial begin
    #100000;
    failures++;
    summarize();
  end

  // ==========
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    cyc();
    rd_op(16'h0240, 16'hffff);
    chk("outputs", 16'h0004, outs());
    rd_op(16'h0002, 16'h0002);
    pulse(sor_clear);
    rd_op(16'h0000, 16'h0002);
    rd_op(16'h0002, 16'h0002);
    hw_status = 1'b1;
    pulse(cor_event);
    wr_op(16'h0000);
    rd_op(16'h0005, 16'h0005);
    rd_op(16'h0000, 16'h0004);
    pulse(w1c_event);
    wr_op(16'h0000);
    rd_op(16'h0010, 16'h0010);
    wr_op(16'h0010);
    rd_op(16'h0000, 16'h0010);
    clash(w1c_event, 16'h0010);
    rd_op(16'h0010, 16'h0010);
    pulse(wac_event);
    wr_op(16'h0000);
    rd_op(16'h0000, 16'h0020);
    clash(wac_event, 16'h0000);
    rd_op(16'h0020, 16'h0020);
    ll_source = 1'b0;
    cyc();
    ll_source = 1'b1;
    cyc();
    rd_op(16'h0000, 16'h0040);
    rd_op(16'h0040, 16'h0040);
    pulse(lh_source);
    rd_op(16'h0080, 16'h0080);
    rd_op(16'h0000, 16'h0080);
    wr_op(16'h0100);
    bit_chk("sc_go", 1'b1, sc_go);
    wr_op(16'h0000);
    bit_chk("sc_go", 1'b1, sc_go);
    pulse(sc_done);
    bit_chk("sc_go", 1'b0, sc_go);
    rd_op(16'h0000, 16'h0100);
    wr_op(16'h0000);
    bit_chk("ss_value", 1'b0, ss_value);
    wr_op(16'h0200);
    bit_chk("ss_value", 1'b0, ss_value);
    pulse(ss_done);
    bit_chk("ss_value", 1'b1, ss_value);
    clash(ss_done, 16'h0000);
    rd_op(16'h0200, 16'h0200);
    wr_op(16'h0000);
    bit_chk("ss_value", 1'b0, ss_value);
    pulse(sticky_cond);
    rd_op(16'h0400, 16'h0400);
    rd_op(16'h0000, 16'h0400);
    sticky_cond = 1'b1;
    cyc();
    rd_op(16'h0400, 16'h0400);
    rd_op(16'h0400, 16'h0400);
    sticky_cond = 1'b0;
    cyc();
    rd_op(16'h0000, 16'h0400);
    for (int i = 0; i < 20; i++) begin
      d = 16'($random(seed)) & 16'h3fff;
      wr_op(d);
      chk("outputs", {10'h000, d[13], d[12], d[11], 2'b00, d[3]}, outs() & 16'h0039);
    end
    wr_op(16'h3808);
    pulse(lite_rst);
    chk("outputs", 16'h000c, outs() & 16'h003d);
    wr_op(16'h3808);
    pulse(soft_rst);
    chk("outputs", 16'h0014, outs() & 16'h003d);
    wr_op(16'h3808);
    pulse(rst);
    chk("outputs", 16'h0004, outs());
    cyc(2);
    chk("notes left", 16'h0000, 16'(notes.size()));
    summarize();
  end
endmodule : rbac_bank_tb_top

`default_nettype wire
